// file: design/lfsm_pkg.sv
// Constants, register map and state type of the mode and fail-safe FSM.
// Assumes a single 50 MHz system clock and a 16-bit register port.
package lfsm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CH_N = 12;
    localparam int DW = 16;
    localparam int AW = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_WDCONF = 8'h01;
    localparam logic [7:0] A_CHEN = 8'h02;
    localparam logic [7:0] A_DIAG = 8'h03;
    localparam logic [7:0] A_MASK = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h05;
    localparam logic [7:0] A_OPEN = 8'h06;
    localparam logic [7:0] A_SHORT = 8'h07;
    localparam logic [7:0] A_CALC_CRC = 8'h08;
    localparam logic [7:0] A_NV_INIT = 8'h10;
    localparam logic [7:0] A_NV_FS0 = 8'h11;
    localparam logic [7:0] A_NV_FS1 = 8'h12;
    localparam logic [7:0] A_NV_DIAG = 8'h13;
    localparam logic [7:0] A_NV_WD = 8'h14;
    localparam logic [7:0] A_NV_CRC = 8'h15;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_POR_CLR = 0;
    localparam int B_FORCE_FS = 1;
    localparam int B_FS_EXIT = 2;
    localparam int B_LOCK = 3;
    localparam int B_OFAF = 4;
    localparam int B_MASK_FATAL = 0;
    localparam int B_MASK_OUT = 1;
    localparam int S_POR = 4;
    localparam int S_ERR = 5;
    localparam int S_LOW = 6;
    localparam int S_REF = 7;
    localparam int S_OT = 8;
    localparam int S_CRC = 9;
    localparam int S_OUT = 10;
    localparam int S_EXT = 11;
    localparam int S_FS1 = 12;

    // ------------------------------------------------------------
    // Reset values of the stored words and mask; top watchdog setting
    // ------------------------------------------------------------
    localparam logic [15:0] RST_NV_INIT = 16'h0005;
    localparam logic [15:0] RST_NV_FS0 = 16'h0fff;
    localparam logic [15:0] RST_NV_FS1 = 16'h0000;
    localparam logic [15:0] RST_NV_DIAG = 16'h0fff;
    localparam logic [15:0] RST_NV_WD = 16'h0008;
    localparam logic [1:0] RST_MASK = 2'h0;
    localparam logic [3:0] WD_MAX_SET = 4'hc;

    function automatic logic [15:0] nvm_crc(input logic [15:0] a,
        input logic [15:0] b, input logic [15:0] c,
        input logic [15:0] d, input logic [15:0] e);
        nvm_crc = a ^ {b[14:0], b[15]} ^ {c[13:0], c[15:14]}
            ^ {d[12:0], d[15:13]} ^ {e[11:0], e[15:12]} ^ 16'h5a5a;
    endfunction

    localparam logic [15:0] RST_NV_CRC = nvm_crc(RST_NV_INIT, RST_NV_FS0,
        RST_NV_FS1, RST_NV_DIAG, RST_NV_WD);

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int RETRY_MS = 10;
    localparam int INIT_STEP_US = 1000;
    localparam int WD_STEP_US = 100;
    localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
    localparam int INIT_STEP_CYC = INIT_STEP_US * CLK_MHZ;
    localparam int WD_STEP_CYC = WD_STEP_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_POR, ST_INIT, ST_NORMAL, ST_FS, ST_LOWQ
    } lfsm_state_t;

endpackage

// file: design/lfsm_timer.sv
// Cycle counter with a done pulse when the limit is reached.
// Assumes limit is at least one; clear restarts the count.
module lfsm_timer
    import lfsm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic [31:0] limit,
    output logic done
);

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_done;

    always_comb begin
        next_cnt = cnt + 32'h1;
        next_done = 1'b0;
        if (clear) begin
            next_cnt = 32'h0;
        end else if (cnt >= limit - 32'h1) begin
            next_cnt = 32'h0;
            next_done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 32'h0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end

endmodule

// file: design/lfsm_chfault.sv
// Per-channel open and short fault flags with timed retry.
// Assumes detector inputs are already deglitched and synchronous.
module lfsm_chfault
    import lfsm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic active,
    input wire logic retry,
    input wire logic low_supply,
    input wire logic [CH_N-1:0] en,
    input wire logic [CH_N-1:0] diag,
    input wire logic [CH_N-1:0] pwm_long,
    input wire logic [CH_N-1:0] open_det,
    input wire logic [CH_N-1:0] short_det,
    output logic [CH_N-1:0] open_flag,
    output logic [CH_N-1:0] short_flag
);

    logic [CH_N-1:0] qual;
    logic [CH_N-1:0] open_hit;
    logic [CH_N-1:0] short_hit;
    logic [CH_N-1:0] next_open;
    logic [CH_N-1:0] next_short;

    always_comb begin
        qual = en & diag & pwm_long;                  // [RL19] [RL20]
        open_hit = qual & open_det & {CH_N{!low_supply}}; // [RL17] [RL19]
        short_hit = qual & short_det;                 // [RL20]
        next_open = open_flag | open_hit;
        next_short = short_flag | short_hit;
        // Retry re-judges the channel; a fault gone clears its flag
        if (retry) begin
            next_open = open_hit;                     // [RL19]
            next_short = short_hit;                   // [RL20]
        end
        if (!active) begin
            next_open = '0;
            next_short = '0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open_flag <= '0;
            short_flag <= '0;
        end else begin
            open_flag <= next_open;
            short_flag <= next_short;
        end
    end

endmodule

// file: design/lfsm_top.sv
// Functional-mode state machine of a 12-channel LED driver.
// Assumes synchronous status inputs and a one-cycle register port.
//
// Operation
// RL1 - Power-on-reset clears registers, disables outputs, refuses access.
// RL2 - Leave power-on-reset for init once supply and LDO are good.
// RL3 - Any rail undervoltage returns to power-on-reset at once.
// RL4 - Init runs delay from 4-bit stored setting, then goes normal.
// RL5 - Init accepts access; power-on clear write enters normal at once.
// RL6 - Init loads stored defaults and holds channel enables at zero.
// RL7 - Normal watchdog counts idle host time, 13 periods, overflow to fail-safe.
// RL8 - Force bit write in normal enters fail-safe immediately.
// RL9 - Every entry to fail-safe from normal reloads defaults.
// RL10 - Select pin high picks set 1 enables, low picks set 0.
// RL11 - Pin level flag mirrors the fail-safe select pin.
// RL12 - Switching fail-safe sets keeps status and flags.
// RL13 - Fail-safe entry sets the configuration lock bit.
// RL14 - Exit needs lock cleared, then exit bit; flags cleared on exit.
// RL15 - All one-fails-all-fail plus fault enters low-current mode, no access.
// RL16 - Undervoltage sets power-on and error flags, error pin low.
// RL17 - Low supply sets flags, blocks open detection, self-clears.
// RL18 - Reference, overtemp or CRC mismatch turn all channels off.
// RL19 - Open fault on qualified channels: off, retry every 10 ms.
// RL20 - Short fault on qualified channels: off, retry, auto recover.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module lfsm_top
    import lfsm_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int INIT_STEP = INIT_STEP_CYC,
    parameter int WD_STEP = WD_STEP_CYC
)
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SUPPLY_OK,
    input wire logic LDO_OK,
    input wire logic LOW_SUPPLY,
    input wire logic REF_FAULT,
    input wire logic OVERTEMP,
    input wire logic FS_SEL,
    input wire logic [CH_N-1:0] PWM_LONG,
    input wire logic [CH_N-1:0] OPEN_DET,
    input wire logic [CH_N-1:0] SHORT_DET,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [AW-1:0] ADDR,
    input wire logic [DW-1:0] WDATA,
    output logic [DW-1:0] RDATA,
    output logic [CH_N-1:0] CH_ON,
    output logic ERR_O,
    output logic ERR_OE
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] init_limit(input logic [3:0] s);
        init_limit = 32'({28'h0, s} + 32'h1) * 32'(INIT_STEP);
    endfunction

    // Settings above the last option behave as the longest period
    function automatic logic [31:0] wd_limit(input logic [3:0] s);
        logic [3:0] k;
        k = (s > WD_MAX_SET) ? WD_MAX_SET : s;
        wd_limit = 32'(WD_STEP) << k;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lfsm_state_t state, next_state;
    logic lock, next_lock;
    logic por_flag, next_por_flag;
    logic fs1, next_fs1;
    logic ext_flag, next_ext_flag;
    logic low_flag, next_low_flag;
    logic ref_flag, next_ref_flag;
    logic ot_flag, next_ot_flag;
    logic crc_flag, next_crc_flag;
    logic [CH_N-1:0] ch_en, next_ch_en;
    logic [CH_N-1:0] diag_en, next_diag_en;
    logic [3:0] wd_set, next_wd_set;
    logic [1:0] mask, next_mask;
    logic [15:0] nv_init, next_nv_init;
    logic [15:0] nv_fs0, next_nv_fs0;
    logic [15:0] nv_fs1, next_nv_fs1;
    logic [15:0] nv_diag, next_nv_diag;
    logic [15:0] nv_wd, next_nv_wd;
    logic [15:0] nv_crc, next_nv_crc;
    logic [15:0] calc_crc, next_calc_crc;
    logic [DW-1:0] next_rdata;
    logic [CH_N-1:0] next_ch_on;
    logic next_err_oe;

    logic rails_ok, acc_ok, wr, rd, in_fs, reload;
    logic fatal, out_any, err_any, ctrl_wr, cfg_wr;
    logic tmr_clear, tmr_done, retry_tick;
    logic [31:0] tmr_limit;
    logic [CH_N-1:0] open_flag, short_flag;

    // ------------------------------------------------------------
    // Timers and channel faults
    // ------------------------------------------------------------
    lfsm_timer u_mode_tmr (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .clear(tmr_clear),
        .limit(tmr_limit),
        .done(tmr_done)
    );

    lfsm_timer u_retry_tmr (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .clear(!in_fs),
        .limit(32'(RETRY_CYCLES)),
        .done(retry_tick)
    );

    lfsm_chfault u_chfault (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .active(in_fs),
        .retry(retry_tick),
        .low_supply(LOW_SUPPLY),
        .en(ch_en),
        .diag(diag_en),
        .pwm_long(PWM_LONG),
        .open_det(OPEN_DET),
        .short_det(SHORT_DET),
        .open_flag(open_flag),
        .short_flag(short_flag)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        rails_ok = SUPPLY_OK && LDO_OK;
        in_fs = (state == ST_FS);
        acc_ok = (state == ST_INIT) || (state == ST_NORMAL) || in_fs;
        wr = WR_EN && acc_ok;                         // [RL1] [RL15]
        rd = RD_EN && acc_ok;                         // [RL1] [RL15]
        ctrl_wr = wr && (ADDR == A_CTRL);
        cfg_wr = wr && !lock;
        fatal = ref_flag || ot_flag || crc_flag;
        out_any = (|open_flag) || (|short_flag);
        err_any = por_flag || low_flag
            || (fatal && !mask[B_MASK_FATAL])
            || (out_any && !mask[B_MASK_OUT]);
        reload = 1'b0;

        next_state = state;
        next_lock = lock;
        next_por_flag = por_flag;
        next_fs1 = fs1;
        next_ext_flag = FS_SEL;                       // [RL11]
        next_low_flag = LOW_SUPPLY;                   // [RL17]
        next_ref_flag = in_fs && REF_FAULT;           // [RL18]
        next_ot_flag = in_fs && OVERTEMP;             // [RL18]
        next_crc_flag = in_fs && (calc_crc != nv_crc); // [RL18]
        next_ch_en = ch_en;
        next_diag_en = diag_en;
        next_wd_set = wd_set;
        next_mask = mask;
        next_nv_init = nv_init;
        next_nv_fs0 = nv_fs0;
        next_nv_fs1 = nv_fs1;
        next_nv_diag = nv_diag;
        next_nv_wd = nv_wd;
        next_nv_crc = nv_crc;
        next_calc_crc = calc_crc;

        // Register writes; the lock only guards configuration
        if (ctrl_wr) begin
            next_lock = WDATA[B_LOCK];
        end
        if (cfg_wr) begin
            case (ADDR)
                A_WDCONF: next_wd_set = WDATA[3:0];
                A_CHEN: begin
                    if (state != ST_INIT) begin       // [RL6]
                        next_ch_en = WDATA[CH_N-1:0];
                    end
                end
                A_DIAG: next_diag_en = WDATA[CH_N-1:0];
                A_MASK: next_mask = WDATA[1:0];
                A_NV_INIT: next_nv_init = WDATA;
                A_NV_FS0: next_nv_fs0 = WDATA;
                A_NV_FS1: next_nv_fs1 = WDATA;
                A_NV_DIAG: next_nv_diag = WDATA;
                A_NV_WD: next_nv_wd = WDATA;
                A_NV_CRC: next_nv_crc = WDATA;
                default: ;
            endcase
        end

        case (state)
            ST_POR: begin
                next_por_flag = 1'b1;                 // [RL16]
                next_low_flag = 1'b0;
                next_lock = 1'b0;
                next_ch_en = '0;                      // [RL1]
                next_mask = RST_MASK;
                if (rails_ok) begin
                    next_state = ST_INIT;             // [RL2] [RL16]
                    reload = 1'b1;
                end
            end
            ST_INIT: begin
                next_ch_en = '0;                      // [RL6]
                if (ctrl_wr && WDATA[B_POR_CLR]) begin
                    next_state = ST_NORMAL;           // [RL5]
                    next_por_flag = 1'b0;
                end else if (tmr_done) begin
                    next_state = ST_NORMAL;           // [RL4]
                end
            end
            ST_NORMAL: begin
                if (ctrl_wr && WDATA[B_POR_CLR]) begin
                    next_por_flag = 1'b0;             // [RL16]
                end
                if ((ctrl_wr && WDATA[B_FORCE_FS]) || tmr_done) begin
                    next_state = ST_FS;               // [RL7] [RL8]
                    reload = 1'b1;                    // [RL9]
                    next_lock = 1'b1;                 // [RL13]
                    next_fs1 = FS_SEL;                // [RL10]
                end
            end
            ST_FS: begin
                // Set change swaps enables and the set-1 flag; fault flags ride through
                if (FS_SEL != fs1) begin
                    next_fs1 = FS_SEL;                // [RL12]
                    next_ch_en = FS_SEL ? nv_fs1[CH_N-1:0]
                        : nv_fs0[CH_N-1:0];           // [RL10]
                end
                if (nv_init[B_OFAF] && (&diag_en)
                    && (fatal || out_any)) begin
                    next_state = ST_LOWQ;             // [RL15]
                end else if (ctrl_wr && WDATA[B_FS_EXIT] && !lock) begin
                    next_state = ST_NORMAL;           // [RL14]
                    next_por_flag = 1'b0;             // [RL14]
                end
            end
            ST_LOWQ: begin
                next_ch_en = ch_en;
            end
            default: next_state = ST_POR;
        endcase

        // Stored words become live settings
        if (reload) begin
            next_diag_en = nv_diag[CH_N-1:0];
            next_wd_set = nv_wd[3:0];
            next_mask = RST_MASK;
            next_calc_crc = nvm_crc(nv_init, nv_fs0, nv_fs1, nv_diag,
                nv_wd);
            if (state == ST_NORMAL) begin
                next_ch_en = FS_SEL ? nv_fs1[CH_N-1:0]
                    : nv_fs0[CH_N-1:0];               // [RL10]
            end else begin
                next_ch_en = '0;                      // [RL6]
            end
        end

        // Undervoltage overrides every other transition
        if (!rails_ok) begin
            next_state = ST_POR;                      // [RL3] [RL16]
        end

        // Watchdog restarts on any accepted host access
        tmr_clear = (next_state != state)
            || !((state == ST_INIT) || (state == ST_NORMAL))
            || ((state == ST_NORMAL) && (wr || rd)); // [RL7]
        tmr_limit = (state == ST_INIT) ? init_limit(nv_init[3:0])
            : wd_limit(wd_set);                       // [RL4] [RL7]

        next_rdata = '0;
        if (rd) begin
            case (ADDR)
                A_CTRL: next_rdata = DW'({lock, 3'h0});
                A_WDCONF: next_rdata = DW'(wd_set);
                A_CHEN: next_rdata = DW'(ch_en);
                A_DIAG: next_rdata = DW'(diag_en);
                A_MASK: next_rdata = DW'(mask);
                A_STATUS: begin
                    next_rdata = DW'(state);
                    next_rdata[S_POR] = por_flag;
                    next_rdata[S_ERR] = err_any;
                    next_rdata[S_LOW] = low_flag;
                    next_rdata[S_REF] = ref_flag;
                    next_rdata[S_OT] = ot_flag;
                    next_rdata[S_CRC] = crc_flag;
                    next_rdata[S_OUT] = out_any;
                    next_rdata[S_EXT] = ext_flag;
                    next_rdata[S_FS1] = fs1;
                end
                A_OPEN: next_rdata = DW'(open_flag);
                A_SHORT: next_rdata = DW'(short_flag);
                A_CALC_CRC: next_rdata = calc_crc;
                A_NV_INIT: next_rdata = nv_init;
                A_NV_FS0: next_rdata = nv_fs0;
                A_NV_FS1: next_rdata = nv_fs1;
                A_NV_DIAG: next_rdata = nv_diag;
                A_NV_WD: next_rdata = nv_wd;
                A_NV_CRC: next_rdata = nv_crc;
                default: next_rdata = '0;
            endcase
        end

        // Outputs
        next_ch_on = '0;                              // [RL1]
        if (state == ST_NORMAL) begin
            next_ch_on = ch_en;
        end else if (in_fs && !fatal) begin          // [RL18]
            next_ch_on = ch_en & ~open_flag & ~short_flag; // [RL19] [RL20]
        end
        next_err_oe = (state == ST_POR)               // [RL16]
            || ((in_fs || state == ST_LOWQ)
            && ((fatal && !mask[B_MASK_FATAL])        // [RL18]
            || (out_any && !mask[B_MASK_OUT])));      // [RL19] [RL20]
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_POR;
            lock <= 1'b0;
            por_flag <= 1'b1;
            fs1 <= 1'b0;
            ext_flag <= 1'b0;
            low_flag <= 1'b0;
            ref_flag <= 1'b0;
            ot_flag <= 1'b0;
            crc_flag <= 1'b0;
            ch_en <= '0;
            diag_en <= RST_NV_DIAG[CH_N-1:0];
            wd_set <= RST_NV_WD[3:0];
            mask <= RST_MASK;
            nv_init <= RST_NV_INIT;
            nv_fs0 <= RST_NV_FS0;
            nv_fs1 <= RST_NV_FS1;
            nv_diag <= RST_NV_DIAG;
            nv_wd <= RST_NV_WD;
            nv_crc <= RST_NV_CRC;
            calc_crc <= RST_NV_CRC;
            RDATA <= '0;
            CH_ON <= '0;
            ERR_OE <= 1'b1;
        end else begin
            state <= next_state;
            lock <= next_lock;
            por_flag <= next_por_flag;
            fs1 <= next_fs1;
            ext_flag <= next_ext_flag;
            low_flag <= next_low_flag;
            ref_flag <= next_ref_flag;
            ot_flag <= next_ot_flag;
            crc_flag <= next_crc_flag;
            ch_en <= next_ch_en;
            diag_en <= next_diag_en;
            wd_set <= next_wd_set;
            mask <= next_mask;
            nv_init <= next_nv_init;
            nv_fs0 <= next_nv_fs0;
            nv_fs1 <= next_nv_fs1;
            nv_diag <= next_nv_diag;
            nv_wd <= next_nv_wd;
            nv_crc <= next_nv_crc;
            calc_crc <= next_calc_crc;
            RDATA <= next_rdata;
            CH_ON <= next_ch_on;
            ERR_OE <= next_err_oe;
        end
    end

    // Open-drain pin only ever pulls low
    assign ERR_O = 1'b0;

endmodule

// file: verification/lfsm_chk.sv
// Port checker of the mode and fail-safe state machine.
// Bound to lfsm_top in the bench; sees the top ports only.
module lfsm_chk
    import lfsm_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SUPPLY_OK,
    input wire logic LDO_OK,
    input wire logic RD_EN,
    input wire logic [DW-1:0] RDATA,
    input wire logic [CH_N-1:0] CH_ON,
    input wire logic ERR_O,
    input wire logic ERR_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence rail_bad;
        !SUPPLY_OK || !LDO_OK;
    endsequence
    sequence rail_back;
        $rose(SUPPLY_OK) && LDO_OK;
    endsequence
    pin_low_a: assert property (ERR_O == 1'b0)
        else $error("error pin value not low");
    sup_err_a: assert property (!SUPPLY_OK |-> ##2 ERR_OE)
        else $error("no error pull after supply loss");
    sup_off_a: assert property (!SUPPLY_OK |-> ##2 CH_ON == '0)
        else $error("channels on after supply loss");
    ldo_off_a: assert property (!LDO_OK |-> ##2 (ERR_OE && CH_ON == '0))
        else $error("no reset action after rail loss");
    por_read_a: assert property (rail_bad ##1 RD_EN |=> RDATA == '0)
        else $error("read answered in reset state");
    rd_stand_a: assert property (RD_EN ##1 !RD_EN |=> RDATA == '0)
        else $error("read data held too long");
    init_dark_a: assert property (rail_back |=> (CH_ON == '0)[*3])
        else $error("channels lit during start-up");
    via_init_a: assert property (rail_bad |-> ##2 (CH_ON == '0)[*3])
        else $error("start-up skipped after rail loss");
endmodule

// file: verification/lfsm_host.sv
// Host model: register port master doing single reads and writes.
// Assumes the design samples strobes at the rising clock edge.
module lfsm_host
    import lfsm_pkg::*;
(
    input wire logic clk,
    input wire logic [DW-1:0] rdata,
    output logic wr_en,
    output logic rd_en,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wdata = '0;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~v; // Stale data would hide a missed strobe
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
endmodule

// file: verification/led_driver_mode_failsafe_fsm_bench.sv
// Self-checking bench of the mode and fail-safe state machine.
// Short timing parameters keep start-up and watchdog counts small.
module led_driver_mode_failsafe_fsm_bench
    import lfsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'b0;
    logic RSTN = 1'b0;
    logic SUPPLY_OK = 1'b1;
    logic LDO_OK = 1'b1;
    logic REF_FAULT = 1'b0;
    logic OVERTEMP = 1'b0;
    logic FS_SEL = 1'b0;
    logic [CH_N-1:0] OPEN_DET = '0;
    logic [CH_N-1:0] SHORT_DET = '0;
    logic WR_EN;
    logic RD_EN;
    logic [AW-1:0] ADDR;
    logic [DW-1:0] WDATA;
    logic [DW-1:0] RDATA;
    logic [CH_N-1:0] CH_ON;
    logic ERR_OE;
    logic [DW-1:0] d;
    int errors = 0;
    int comparisons = 0;
    always #10 CLK_SYS = ~CLK_SYS;
    lfsm_top #(.RETRY_CYCLES(20), .INIT_STEP(4), .WD_STEP(4)) dut (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .SUPPLY_OK(SUPPLY_OK),
        .LDO_OK(LDO_OK), .LOW_SUPPLY(1'b0), .REF_FAULT(REF_FAULT),
        .OVERTEMP(OVERTEMP), .FS_SEL(FS_SEL), .PWM_LONG(12'hfff),
        .OPEN_DET(OPEN_DET), .SHORT_DET(SHORT_DET), .WR_EN(WR_EN),
        .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
        .CH_ON(CH_ON), .ERR_O(), .ERR_OE(ERR_OE));
    lfsm_host host (.clk(CLK_SYS), .rdata(RDATA), .wr_en(WR_EN),
        .rd_en(RD_EN), .addr(ADDR), .wdata(WDATA));
    // ------------------------------------------------------------
    // Helpers and scenarios
    // ------------------------------------------------------------
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stat(input logic [DW-1:0] exp);
        host.rd(A_STATUS, d);
        chk(d, exp);
    endtask
    task automatic pins(input logic [DW-1:0] exp);
        chk({3'h0, ERR_OE, CH_ON}, exp);
    endtask
    task automatic t_init();
        repeat (2) @(posedge CLK_SYS);
        stat(16'h0031);
        pins(16'h0000);
        repeat (30) @(posedge CLK_SYS);
        stat(16'h0032);
    endtask
    task automatic t_uv();
        @(posedge CLK_SYS);
        {SUPPLY_OK, LDO_OK} <= 2'h0;
        repeat (3) @(posedge CLK_SYS);
        pins(16'h1000);
        {SUPPLY_OK, LDO_OK} <= 2'h3;
        stat(16'h0031);
        host.wr(A_CTRL, 16'h0001);
        stat(16'h0002);
    endtask
    task automatic t_force();
        host.wr(A_CTRL, 16'h0002);
        repeat (2) @(posedge CLK_SYS);
        pins({4'h0, RST_NV_FS0[11:0]});
        stat(16'h0003);
        host.rd(A_CTRL, d);
        chk(d, 16'h0008);
    endtask
    task automatic t_fault();
        for (int i = 1; i < 3; i++) begin
            @(posedge CLK_SYS);
            {OVERTEMP, REF_FAULT} <= 2'(i);
            repeat (4) @(posedge CLK_SYS);
            pins(16'h1000);
            {OVERTEMP, REF_FAULT} <= 2'h0;
            repeat (4) @(posedge CLK_SYS);
            pins(16'h0fff);
        end
    endtask
    task automatic t_open();
        @(posedge CLK_SYS);
        {SHORT_DET, OPEN_DET} <= 24'h002001;
        repeat (4) @(posedge CLK_SYS);
        pins(16'h1ffc);
        host.rd(A_OPEN, d);
        chk(d, 16'h0001);
        @(posedge CLK_SYS);
        {SHORT_DET, OPEN_DET} <= '0;
        repeat (45) @(posedge CLK_SYS);
        pins(16'h0fff);
    endtask
    task automatic t_sel();
        @(posedge CLK_SYS);
        FS_SEL <= 1'b1;
        host.rd(A_STATUS, d);
        chk(d & 16'h0800, 16'h0800);
        @(posedge CLK_SYS);
        FS_SEL <= 1'b0;
        host.rd(A_STATUS, d);
        chk(d & 16'h0800, 16'h0000);
    endtask
    task automatic t_exit();
        host.wr(A_CTRL, 16'h000c);
        stat(16'h0003);
        host.wr(A_CTRL, 16'h0000);
        host.wr(A_CTRL, 16'h0004);
        stat(16'h0002);
        host.wr(A_NV_CRC, ~RST_NV_CRC);
        host.rd(8'h20, d);
        chk(d, 16'h0000);
    endtask
    task automatic t_wd();
        repeat (1000) @(posedge CLK_SYS);
        stat(16'h0002);
        repeat (1030) @(posedge CLK_SYS);
        stat(16'h0223);
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        t_init();
        t_uv();
        t_force();
        t_fault();
        t_open();
        t_sel();
        t_exit();
        t_wd();
        end_sim();
    end
endmodule
bind lfsm_top lfsm_chk chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .SUPPLY_OK(SUPPLY_OK), .LDO_OK(LDO_OK), .RD_EN(RD_EN), .RDATA(RDATA),
    .CH_ON(CH_ON), .ERR_O(ERR_O), .ERR_OE(ERR_OE));
